/* File: sas_params.svh */
// Offsets, reset values and cycle counts of the converter sequencer
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
`define SAS_CLK_PERIOD_NS    40
`define SAS_RES_BITS         12
`define SAS_FIFO_DEPTH       32
`define SAS_SAMPLE_CYC       2
`define SAS_GAP_CYC          3
`define SAS_STROBE_CYC       1
`define SAS_OFF_CTRL         8'h00
`define SAS_OFF_STATUS       8'h04
`define SAS_OFF_RESULT       8'h08
`define SAS_OFF_COUNT        8'h0C
`define SAS_CTRL_HOLD_BIT    0
`define SAS_CTRL_RST         32'h00000000
`define SAS_ST_BUSY_BIT      0
`define SAS_ST_ENABLE_BIT    1
`define SAS_ST_MODE_LSB      2
`define SAS_ST_LEVEL_LSB     8
`define SAS_ST_SHIFT_BIT     16
`endif

/* File: sas_pkg.sv */
// Types shared by the converter sequencer
package sas_pkg;
  typedef enum logic [1:0] {
    SAS_MODE_SINGLE   = 2'b00,
    SAS_MODE_DISABLED = 2'b01,
    SAS_MODE_CONT_LSB = 2'b10,
    SAS_MODE_CONT_MSB = 2'b11
  } sas_mode_e;
  // Host-side pins, each taken straight from a package ball
  typedef struct packed {
    logic conversion_enable_n;
    logic channel_sel_1;
    logic channel_sel_0;
    logic mode_sel_1;
    logic mode_sel_0;
  } sas_pins_s;
  // AHB-Lite request from the one master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } sas_ahb_req_s;
  // Analog front end controls
  typedef struct packed {
    logic        sample_hold;
    logic [1:0]  channel;
    logic [11:0] dac_code;
  } sas_afe_s;
endpackage

/* File: sas_sequencer.sv */
// Converter sequencer: SAR control, result FIFO, serial readout and AHB-Lite registers
// Summary of operation
// - Each 12-bit result leaves one bit at a time on the serial output, changing on clock rises.
// - Conversion starts when the enable pin goes low and stops whenever it returns high.
// - With enable high, serial output and sample strobe are both released (enables low).
// - The two channel-select pins pick analog input 0 to 3 as a binary number.
// - Mode pins: 00 single, only bit 1 high LSB-first continuous, 11 MSB-first continuous; 01 unused.
// - Each result is preceded by a one-cycle strobe; bits start three cycles after it falls.
// - In single mode the output is held low after the 12 bits and no more conversions run.
// - Single mode sends the most significant bit first.
// - Continuous modes convert back to back while enable stays low.
// - LSB-first continuous mode sends the least significant bit first.
// - In LSB-first continuous mode the first bit appears 23 cycles after enable falls.
// - MSB-first continuous mode sends the most significant bit first.
// - The channel selection is latched at the start of each sampling phase.
// - Each result is found by successive approximation, one bit a step from the top down.
`timescale 1ns/100ps
`include "sas_params.svh"

// Result buffer between the converter and the serial readout
module sas_fifo #(
  parameter int WIDTH = `SAS_RES_BITS,
  parameter int DEPTH = `SAS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     flush_i,
  // Filling side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Draining side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]    level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [LW-1:0]    level_r;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill count
  assign in_ready_o  = (level_r != LW'(DEPTH));
  assign out_valid_o = (level_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign level_o     = level_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage needs no reset; only the pointers define contents
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers wrap naturally since the depth is a power of two
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        level_r <= level_r + LW'(1);
      end else if (pop && !push) begin
        level_r <= level_r - LW'(1);
      end
    end
  end
endmodule // sas_fifo

// Top of the converter's digital side
module sas_sequencer (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Host pins
  input  wire sas_pkg::sas_pins_s pins_i,
  output logic                    serial_result_o,
  output logic                    serial_result_oe_o,
  output logic                    sample_strobe_o,
  output logic                    sample_strobe_oe_o,
  // Analog front end
  input  wire logic               comparator_i,
  output sas_pkg::sas_afe_s       afe_o,
  // AHB-Lite slave
  input  wire sas_pkg::sas_ahb_req_s ahb_i,
  output logic [31:0]             hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o
);
  import sas_pkg::*;

  typedef enum logic [2:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONV, SAR_PUSH, SAR_DONE} sas_sar_e;
  typedef enum logic [1:0] {SER_IDLE, SER_STROBE, SER_GAP, SER_SHIFT} sas_ser_e;

  localparam int RB = `SAS_RES_BITS;
  localparam int LW = $clog2(`SAS_FIFO_DEPTH + 1);

  // Pick the outgoing bit for a given position and bit order
  function automatic logic sel_bit(input logic [RB-1:0] word, input logic [3:0] idx,
                                   input logic msb_first);
    logic [3:0] pos;
    pos = msb_first ? 4'(RB - 1 - int'(idx)) : idx;
    return word[pos];
  endfunction

  // Pin synchroniser, first stage is read by the second only
  logic [4:0]  pin_ff1_r;
  logic [4:0]  pin_ff2_r;
  sas_pins_s   pins_s;
  logic        en_act;
  sas_mode_e   pin_mode;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_ff1_r <= 5'h1F;
      pin_ff2_r <= 5'h1F;
    end else begin
      pin_ff1_r <= pins_i;
      pin_ff2_r <= pin_ff1_r;
    end
  end

  assign pins_s   = sas_pins_s'(pin_ff2_r);
  assign en_act   = ~pins_s.conversion_enable_n;
  assign pin_mode = sas_mode_e'({pins_s.mode_sel_1, pins_s.mode_sel_0});

  // Registers and converter state
  logic            hold_r;
  logic [RB-1:0]   last_result_r;
  logic [15:0]     conv_count_r;
  sas_sar_e        sar_state_r;
  sas_mode_e       mode_r;
  logic [3:0]      step_r;
  logic [RB-1:0]   trial_r;
  logic [1:0]      channel_r;
  logic [1:0]      sample_strobe_cnt_r;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic            fifo_out_ready;
  logic [RB-1:0]   fifo_out_data;
  logic [LW-1:0]   fifo_level;
  logic            fifo_push;
  logic            continuous;

  assign continuous = (mode_r == SAS_MODE_CONT_LSB) || (mode_r == SAS_MODE_CONT_MSB);
  assign fifo_push  = (sar_state_r == SAR_PUSH);

  // Converter sequence: sample, twelve compare steps, hand result to the buffer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sar_state_r <= SAR_IDLE;
      mode_r      <= SAS_MODE_SINGLE;
      sample_strobe_cnt_r  <= 2'h0;
      step_r      <= 4'h0;
      trial_r     <= 12'h000;
      channel_r   <= 2'h0;
    end else if (!en_act) begin
      sar_state_r <= SAR_IDLE;
    end else begin
      case (sar_state_r)
        SAR_IDLE: begin
          // The unused mode combination never starts a conversion
          if (pin_mode != SAS_MODE_DISABLED) begin
            mode_r      <= pin_mode;
            channel_r   <= {pins_s.channel_sel_1, pins_s.channel_sel_0};
            sample_strobe_cnt_r  <= 2'h0;
            sar_state_r <= SAR_SAMPLE;
          end
        end
        SAR_SAMPLE: begin
          if (sample_strobe_cnt_r == 2'(`SAS_SAMPLE_CYC - 1)) begin
            step_r      <= 4'(RB - 1);
            trial_r     <= 12'h800;
            sar_state_r <= SAR_CONV;
          end else begin
            sample_strobe_cnt_r <= sample_strobe_cnt_r + 2'h1;
          end
        end
        SAR_CONV: begin
          // Keep the trial bit only if the input is at or above the trial level
          if (!comparator_i) begin
            trial_r[step_r] <= 1'b0;
          end
          if (step_r == 4'h0) begin
            sar_state_r <= SAR_PUSH;
          end else begin
            trial_r[step_r - 4'h1] <= 1'b1;
            step_r <= step_r - 4'h1;
          end
        end
        SAR_PUSH: begin
          // A full buffer stalls the converter here instead of losing a result
          if (fifo_in_ready) begin
            if (continuous) begin
              channel_r   <= {pins_s.channel_sel_1, pins_s.channel_sel_0};
              sample_strobe_cnt_r  <= 2'h0;
              sar_state_r <= SAR_SAMPLE;
            end else begin
              sar_state_r <= SAR_DONE;
            end
          end
        end
        SAR_DONE: sar_state_r <= SAR_DONE;
        default:  sar_state_r <= SAR_IDLE;
      endcase
    end
  end

  // Result buffer, flushed whenever enable is released
  sas_fifo #(
    .WIDTH (RB),
    .DEPTH (`SAS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .flush_i     (~en_act),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (trial_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  // Serial readout state
  sas_ser_e        ser_state_r;
  logic [RB-1:0]   shift_word_r;
  logic [3:0]      bit_idx_r;
  logic [1:0]      gap_cnt_r;
  logic            ser_r;
  logic            strobe_r;
  logic            oe_r;
  logic            msb_first;

  assign msb_first      = (mode_r != SAS_MODE_CONT_LSB);
  assign fifo_out_ready = (ser_state_r == SER_IDLE) && !hold_r && en_act;

  // Strobe, three quiet cycles, then twelve bits
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ser_state_r  <= SER_IDLE;
      shift_word_r <= 12'h000;
      bit_idx_r    <= 4'h0;
      gap_cnt_r    <= 2'h0;
      ser_r        <= 1'b0;
      strobe_r     <= 1'b0;
    end else if (!en_act) begin
      ser_state_r <= SER_IDLE;
      ser_r       <= 1'b0;
      strobe_r    <= 1'b0;
    end else begin
      case (ser_state_r)
        SER_IDLE: begin
          if (fifo_out_valid && fifo_out_ready) begin
            shift_word_r <= fifo_out_data;
            strobe_r     <= 1'b1;
            ser_state_r  <= SER_STROBE;
          end
        end
        SER_STROBE: begin
          strobe_r    <= 1'b0;
          gap_cnt_r   <= 2'h0;
          ser_state_r <= SER_GAP;
        end
        SER_GAP: begin
          if (gap_cnt_r == 2'(`SAS_GAP_CYC - 1)) begin
            ser_r       <= sel_bit(shift_word_r, 4'h0, msb_first);
            bit_idx_r   <= 4'h1;
            ser_state_r <= SER_SHIFT;
          end else begin
            gap_cnt_r <= gap_cnt_r + 2'h1;
          end
        end
        SER_SHIFT: begin
          if (bit_idx_r == 4'(RB)) begin
            ser_r       <= 1'b0;
            ser_state_r <= SER_IDLE;
          end else begin
            ser_r     <= sel_bit(shift_word_r, bit_idx_r, msb_first);
            bit_idx_r <= bit_idx_r + 4'h1;
          end
        end
        default: ser_state_r <= SER_IDLE;
      endcase
    end
  end

  // Pin drivers are released one cycle after enable is seen high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= en_act;
    end
  end

  assign serial_result_o    = ser_r;
  assign serial_result_oe_o = oe_r;
  assign sample_strobe_o    = strobe_r;
  assign sample_strobe_oe_o = oe_r;
  assign afe_o.sample_hold  = (sar_state_r == SAR_SAMPLE);
  assign afe_o.channel      = channel_r;
  assign afe_o.dac_code     = trial_r;

  // Result history for software, counted at the hand-off to the buffer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_result_r <= 12'h000;
      conv_count_r  <= 16'h0000;
    end else if (fifo_push && fifo_in_ready) begin
      last_result_r <= trial_r;
      conv_count_r  <= conv_count_r + 16'h0001;
    end
  end

  // AHB-Lite: zero wait states, always OKAY
  logic        dphase_wr_r;
  logic [7:0]  dphase_addr_r;
  logic        addr_take;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] hrdata_r;

  assign addr_take   = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;

  // Status word gathers live state of both engines
  always_comb begin
    status_word = 32'h00000000;
    status_word[`SAS_ST_BUSY_BIT]   = (sar_state_r != SAR_IDLE) && (sar_state_r != SAR_DONE);
    status_word[`SAS_ST_ENABLE_BIT] = en_act;
    status_word[`SAS_ST_MODE_LSB +: 2] = mode_r;
    status_word[`SAS_ST_LEVEL_LSB +: LW] = fifo_level;
    status_word[`SAS_ST_SHIFT_BIT]  = (ser_state_r != SER_IDLE);
  end

  // Read decode; unmapped words read zero
  always_comb begin
    case (ahb_i.haddr[7:0])
      `SAS_OFF_CTRL:   rd_word = {31'h00000000, hold_r};
      `SAS_OFF_STATUS: rd_word = status_word;
      `SAS_OFF_RESULT: rd_word = {20'h00000, last_result_r};
      `SAS_OFF_COUNT:  rd_word = {16'h0000, conv_count_r};
      default:         rd_word = 32'h00000000;
    endcase
  end

  // Read data is captured in the address phase so it stands in the data phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dphase_wr_r   <= 1'b0;
      dphase_addr_r <= 8'h00;
      hrdata_r      <= 32'h00000000;
    end else if (ahb_i.hready) begin
      dphase_wr_r   <= addr_take && ahb_i.hwrite;
      dphase_addr_r <= ahb_i.haddr[7:0];
      if (addr_take && !ahb_i.hwrite) begin
        hrdata_r <= rd_word;
      end
    end
  end

  // Control write in the data phase; hold stalls the readout, not the converter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_r <= 1'(`SAS_CTRL_RST);
    end else if (dphase_wr_r && (dphase_addr_r == `SAS_OFF_CTRL)) begin
      hold_r <= ahb_i.hwdata[`SAS_CTRL_HOLD_BIT];
    end
  end
endmodule // sas_sequencer

/* File: sas_sequencer_chk.sv */
// Assertion checker for the converter sequencer ports
`timescale 1ns/100ps
module sas_sequencer_chk (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  // Host pins
  input wire sas_pkg::sas_pins_s    pins_i,
  input wire logic                  serial_result_o,
  input wire logic                  serial_result_oe_o,
  input wire logic                  sample_strobe_o,
  input wire logic                  sample_strobe_oe_o,
  // Analog front end
  input wire logic                  comparator_i,
  input wire sas_pkg::sas_afe_s     afe_o,
  // AHB-Lite slave
  input wire sas_pkg::sas_ahb_req_s ahb_i,
  input wire logic [31:0]           hrdata_o,
  input wire logic                  hreadyout_o,
  input wire logic                  hresp_o
);
  import sas_pkg::*;
  logic [9:0] low_r;
  logic [4:0] since_r;
  logic [3:0] strb_r;
  wire        en_n = pins_i.conversion_enable_n;
  wire  [1:0] mode = {pins_i.mode_sel_1, pins_i.mode_sel_0};
  wire  [1:0] chan = {pins_i.channel_sel_1, pins_i.channel_sel_0};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Length of the current enable-low run, counted at the raw pin
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i || en_n) low_r <= 10'h000;
    else if (low_r != 10'h3FF) low_r <= low_r + 10'h001;
  end
  // Strobes seen in this run; cleared when enable returns high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i || en_n) strb_r <= 4'h0;
    else if (sample_strobe_o && strb_r != 4'hF) strb_r <= strb_r + 4'h1;
  end
  // Cycles since the last strobe; saturates so it never wraps into the bit window
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) since_r <= 5'h00;
    else if (sample_strobe_o) since_r <= 5'h01;
    else if (since_r != 5'h00 && since_r != 5'h1F) since_r <= since_r + 5'h01;
  end
  // Control writes seen on the bus; a held readout delays the first strobe on purpose
  logic       wr_ctrl_r;
  logic       held_r;
  logic       run_held_r;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ctrl_r  <= 1'b0;
      held_r     <= 1'b0;
      run_held_r <= 1'b0;
    end else begin
      if (ahb_i.hready) begin
        wr_ctrl_r <= ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hwrite && (ahb_i.haddr[7:0] == 8'h00);
      end
      if (wr_ctrl_r) begin
        held_r <= ahb_i.hwdata[0];
      end
      run_held_r <= en_n ? held_r : (run_held_r || held_r);
    end
  end
  property p_strobe_pulse; sample_strobe_o |=> !sample_strobe_o; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_bits; serial_result_o |-> since_r inside {[4:15]}; endproperty
  a_bits: assert property (p_bits) else $error("data bit outside its window");
  property p_float; en_n [*4] |-> !serial_result_oe_o && !sample_strobe_oe_o; endproperty
  a_float: assert property (p_float) else $error("pins driven while disabled");
  property p_first;
    sample_strobe_o && strb_r == 4'h0 && !run_held_r |-> low_r inside {[17:19]};
  endproperty
  a_first: assert property (p_first) else $error("first strobe late or early");
  property p_single_once; sample_strobe_o && mode == 2'b00 |-> strb_r == 4'h0; endproperty
  a_single_once: assert property (p_single_once) else $error("second single word");
  property p_single_low;
    mode == 2'b00 && strb_r != 4'h0 && since_r >= 5'd16 |-> !serial_result_o;
  endproperty
  a_single_low: assert property (p_single_low) else $error("output not held low");
  property p_disabled; mode == 2'b01 && !en_n |-> !sample_strobe_o; endproperty
  a_disabled: assert property (p_disabled) else $error("disabled mode converts");
  property p_chan;
    $rose(afe_o.sample_hold) && chan == $past(chan, 4) |-> afe_o.channel == chan;
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel latched");
  property p_sar;
    $fell(afe_o.sample_hold) && low_r > 10'd3 |-> afe_o.dac_code == 12'h800
      ##1 afe_o.dac_code == {$past(comparator_i), 11'h400};
  endproperty
  a_sar: assert property (p_sar) else $error("trial code sequence wrong");
  property p_bus; ahb_i.hsel && ahb_i.htrans[1] |=> hreadyout_o && !hresp_o; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  c_single: cover property (sample_strobe_o && mode == 2'b00);
  c_lsb: cover property (sample_strobe_o && mode == 2'b10);
  c_msb: cover property (sample_strobe_o && mode == 2'b11);
endmodule // sas_sequencer_chk

bind sas_sequencer sas_sequencer_chk sas_sequencer_chk_i (.clk_i, .reset_i, .pins_i,
  .serial_result_o, .serial_result_oe_o, .sample_strobe_o, .sample_strobe_oe_o,
  .comparator_i, .afe_o, .ahb_i, .hrdata_o, .hreadyout_o, .hresp_o);

/* File: sas_host_model.sv */
// Host controller model: drives the select pins and collects serial words
`timescale 1ns/100ps
module sas_host_model (
  // Clock
  input  wire logic          clk_i,
  // Pins toward the converter
  output sas_pkg::sas_pins_s pins_o,
  input  wire logic          serial_line_i,
  input  wire logic          strobe_line_i
);
  import sas_pkg::*;
  logic [11:0] shift_r;
  logic [11:0] nxt;
  int          wait_r = 0;
  int          bits_r = 0;
  logic [11:0] words [$];
  // Enable inactive from time zero
  initial pins_o = 5'h10;
  // Mode and channel settle a cycle before enable falls
  task automatic start(input sas_mode_e m, input logic [1:0] ch);
    @(posedge clk_i);
    pins_o <= {1'b1, ch, m};
    @(posedge clk_i);
    pins_o.conversion_enable_n <= 1'b0;
  endtask
  // A new channel may come at any time; it applies from the next sampling on
  task automatic set_chan(input logic [1:0] ch);
    @(posedge clk_i);
    {pins_o.channel_sel_1, pins_o.channel_sel_0} <= ch;
  endtask
  // Enable is held high long enough for the outputs to float
  task automatic stop;
    @(posedge clk_i);
    pins_o.conversion_enable_n <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  // First bit stands four edges after the strobe; a word cut short by raising
  // enable is dropped, so a floating line never ends up in the next run's queue
  always @(posedge clk_i) begin
    nxt = (pins_o.mode_sel_1 && !pins_o.mode_sel_0) ? {serial_line_i, shift_r[11:1]}
                                                      : {shift_r[10:0], serial_line_i};
    if (pins_o.conversion_enable_n) begin
      wait_r <= 0;
    end else if (wait_r == 0 && strobe_line_i === 1'b1) begin
      wait_r <= 4;
      bits_r <= 0;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end else if (wait_r == 1) begin
      shift_r <= nxt;
      bits_r <= bits_r + 1;
      if (bits_r == 11) begin
        words.push_back(nxt);
        wait_r <= 0;
      end
    end
  end
endmodule // sas_host_model

/* File: test_sas_sequencer_sequencer.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module test_sas_sequencer;
  import sas_pkg::*;
  logic         clk_i = 1'b0;
  logic         reset_i = 1'b1;
  sas_pins_s    pins_i;
  logic         serial_result_o, serial_result_oe_o, sample_strobe_o, sample_strobe_oe_o;
  logic         comparator_i, hreadyout_o, hresp_o;
  sas_afe_s     afe_o;
  sas_ahb_req_s ahb_r, ahb_i;
  logic [31:0]  hrdata_o;
  logic [11:0]  analog [4] = '{12'h000, 12'h5A3, 12'hC3C, 12'hFFF};
  int           error_cnt = 0;
  int           checks_done = 0;
  wire          ser_line = serial_result_oe_o ? serial_result_o : 1'bz;
  wire          strb_line = sample_strobe_oe_o ? sample_strobe_o : 1'bz;
  always #20 clk_i = ~clk_i;
  // Ideal comparator: the result equals the selected input value
  assign comparator_i = analog[afe_o.channel] >= afe_o.dac_code;
  // The one slave's ready is the bus ready
  always_comb begin
    ahb_i = ahb_r;
    ahb_i.hready = hreadyout_o;
  end
  sas_sequencer sas_sequencer_i (.clk_i, .reset_i, .pins_i, .serial_result_o,
    .serial_result_oe_o, .sample_strobe_o, .sample_strobe_oe_o, .comparator_i, .afe_o,
    .ahb_i, .hrdata_o, .hreadyout_o, .hresp_o);
  sas_host_model sas_host_model_i (.clk_i, .pins_o(pins_i), .serial_line_i(ser_line),
    .strobe_line_i(strb_line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Single word transfer; address phase, then data phase, each until ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    ahb_r <= '{1'b1, {24'h000000, a}, 2'b10, wr, 3'b010, ahb_r.hwdata, 1'b0};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    ahb_r.hsel <= 1'b0;
    ahb_r.htrans <= 2'b00;
    ahb_r.hwdata <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic wait_words(input int n, input int lim);
    int i;
    i = 0;
    while (sas_host_model_i.words.size() < n && i < lim) begin
      @(posedge clk_i);
      i++;
    end
  endtask
  task automatic test_reset;
    logic [31:0] d;
    chk({30'h0, serial_result_oe_o, sample_strobe_oe_o}, 32'h0, "oe idle");
    bus(1'b0, 8'h00, 32'h0, d);
    chk(d, 32'h0, "ctrl reset");
    bus(1'b0, 8'h0C, 32'h0, d);
    chk(d, 32'h0, "count reset");
    bus(1'b1, 8'h10, 32'hFFFFFFFF, d);
    bus(1'b0, 8'h10, 32'h0, d);
    chk(d, 32'h0, "unmapped");
    $display("test_reset done");
  endtask
  // Every channel once; a channel change alone must not restart
  task automatic test_single;
    logic [31:0] d;
    for (int ch = 0; ch < 4; ch++) begin
      sas_host_model_i.words.delete();
      sas_host_model_i.start(SAS_MODE_SINGLE, ch[1:0]);
      wait_words(1, 60);
      sas_host_model_i.set_chan(~ch[1:0]);
      repeat (60) @(posedge clk_i);
      chk(sas_host_model_i.words.size(), 1, "word count");
      chk(sas_host_model_i.words[0], analog[ch], "single word");
      chk({serial_result_oe_o, serial_result_o}, 2'b10, "held low");
      sas_host_model_i.stop();
      chk(serial_result_oe_o, 1'b0, "released");
    end
    bus(1'b0, 8'h08, 32'h0, d);
    chk(d[11:0], analog[3], "result reg");
    $display("test_single done");
  endtask
  // Both continuous orders, with a channel change in mid-run
  task automatic test_cont;
    for (int k = 0; k < 2; k++) begin
      sas_host_model_i.words.delete();
      sas_host_model_i.start(k ? SAS_MODE_CONT_MSB : SAS_MODE_CONT_LSB, 2'h1);
      wait_words(2, 80);
      sas_host_model_i.set_chan(2'h2);
      wait_words(6, 120);
      chk(sas_host_model_i.words.size(), 6, "words");
      chk(sas_host_model_i.words[0], analog[1], "cont word");
      chk(sas_host_model_i.words[1], analog[1], "cont word");
      chk(sas_host_model_i.words[5], analog[2], "new chan");
      sas_host_model_i.stop();
    end
    $display("test_cont done");
  endtask
  task automatic test_disabled;
    sas_host_model_i.words.delete();
    sas_host_model_i.start(SAS_MODE_DISABLED, 2'h0);
    repeat (80) @(posedge clk_i);
    chk(sas_host_model_i.words.size(), 0, "disabled");
    sas_host_model_i.stop();
    $display("test_disabled done");
  endtask
  // Hold the readout until the buffer refuses, then drain it
  task automatic test_fifo;
    logic [31:0] d;
    sas_host_model_i.words.delete();
    bus(1'b1, 8'h00, 32'h1, d);
    bus(1'b0, 8'h00, 32'h0, d);
    chk(d, 32'h1, "ctrl back");
    sas_host_model_i.start(SAS_MODE_CONT_MSB, 2'h3);
    repeat (700) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0, d);
    chk(d[13:8], 6'h20, "full");
    chk(sas_host_model_i.words.size(), 0, "held");
    bus(1'b1, 8'h00, 32'h0, d);
    wait_words(32, 640);
    chk(sas_host_model_i.words[0], analog[3], "drain first");
    chk(sas_host_model_i.words[31], analog[3], "drain last");
    sas_host_model_i.stop();
    bus(1'b0, 8'h04, 32'h0, d);
    chk(d[13:8], 6'h00, "flushed");
    $display("test_fifo done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence; the bus idles from time zero
  initial begin
    ahb_r = '0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    test_reset;
    test_single;
    test_cont;
    test_disabled;
    test_fifo;
    stop_test;
  end
  // The tests take about 2100 cycles, so this limit only trips on a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    stop_test;
  end
endmodule // test_sas_sequencer
